// ==== core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// core stand-in: instruction boundaries and program counter
module core_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic vector_load,
    input wire logic [12:0] vector_pc,
    input wire logic core_asleep,
    output logic [12:0] current_pc,
    output logic instr_cycle_end
);
    logic [1:0] phase_r;
    // one instruction every four clocks, boundary pulse runs even asleep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= 2'h0;
            instr_cycle_end <= 1'b0;
            current_pc <= 13'h0100;
        end else begin
            phase_r <= phase_r + 2'h1;
            instr_cycle_end <= (phase_r == 2'h2);
            // a vector beats the normal step
            if (vector_load) begin
                current_pc <= vector_pc;
            end else if (instr_cycle_end && !core_asleep) begin
                current_pc <= current_pc + 13'h0001;
            end
        end
    end
endmodule // core_model
`default_nettype wire

// ==== interrupt_controller_core.sv ====
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - eleven sources, each latched in its own flag bit
// - flags set by events whatever the enables say
// - global enable at main control bit 7 gates every source
// - enabled flag with global enable set vectors the core at the next instruction boundary
// - any reset clears the global enable
// - return-from-interrupt sets the global enable again
// - pin, port-change and timer flags with enables live in main control
// - peripheral flags and enables in two register pairs, group gated
// - acknowledge clears global enable, pushes return address, vectors 0004h
// - an external pin event reaches the vector three to six clocks later, within two instruction cycles
// - wake by interrupt with enable set runs PC+1 then vectors 0004h
// - a wake always leaves at least one flag set
// - pin flag on rising edge if edge select set, else falling
// - timer wrap FFh to 00h sets the timer flag at bit 2
// - change on port pins 7 to 4 sets the port-change flag at bit 0
module interrupt_controller_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_edge_irq_pin,
    input wire logic [3:0] port_b_pins,
    input wire logic [7:0] timer_zero_count,
    input wire irq_pkg::periph_events_t periph_events,
    input wire logic [12:0] current_pc,
    input wire logic instr_cycle_end,
    input wire logic return_from_irq_instr,
    input wire logic irq_disable_instr,
    input wire logic sleep_instr,
    output logic irq_to_core,
    output logic vector_load,
    output logic [12:0] vector_pc,
    output logic push_return,
    output logic [12:0] push_addr,
    output logic core_asleep,
    output logic wake_up
);
    // ==========================================================
    // register state
    logic [7:0] irq_main_control_reg_r;
    logic [6:0] periph_flag_reg_one_r;
    logic [0:0] periph_flag_reg_two_r;
    logic [6:0] periph_enable_reg_one_r;
    logic [0:0] periph_enable_reg_two_r;
    logic [7:0] option_r;
    irq_pkg::core_state_t core_state_r;
    logic global_irq_enable;
    logic ext_edge_select;
    assign global_irq_enable =
        irq_main_control_reg_r[irq_pkg::GLOBAL_EN_BIT];
    assign ext_edge_select = option_r[irq_pkg::EDGE_SEL_BIT];

    function automatic logic wr_hit(input logic [7:0] a,
                                    input logic [7:0] target);
        wr_hit = (a == target);
    endfunction

    // ==========================================================
    // AXI4-Lite write path
    logic [7:0] aw_addr_r;
    logic aw_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic w_held_r;
    logic wr_fire;
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= irq_pkg::AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_r > irq_pkg::ADDR_CORE ||
                    aw_addr_r[1:0] != 2'h0) ? irq_pkg::AXI_SLVERR
                    : irq_pkg::AXI_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_lane0;
    assign wr_lane0 = wr_fire && w_strb_r[0];

    // ==========================================================
    // event detection
    logic [1:0] ext_pipe_r;
    logic [3:0] port_last_r;
    logic [7:0] tmr_last_r;
    logic ext_event;
    logic port_event;
    logic tmr_event;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // start from the pins' own level so release makes no edge
            ext_pipe_r <= {2{ext_edge_irq_pin}};
            port_last_r <= port_b_pins;
            tmr_last_r <= 8'h00;
        end else begin
            ext_pipe_r <= {ext_pipe_r[0], ext_edge_irq_pin};
            port_last_r <= port_b_pins;
            tmr_last_r <= timer_zero_count;
        end
    end
    // two stages of delay set the pin flag two clocks after the pin, the vector three to six clocks after
    assign ext_event = ext_edge_select ?
        (ext_pipe_r[0] && !ext_pipe_r[1]) :
        (!ext_pipe_r[0] && ext_pipe_r[1]);
    assign port_event = (port_b_pins != port_last_r);
    assign tmr_event = (tmr_last_r == 8'hFF) &&
        (timer_zero_count == 8'h00);

    // ==========================================================
    // request logic
    logic pin_req;
    logic periph_req;
    logic any_req;
    assign pin_req =
        (irq_main_control_reg_r[irq_pkg::RB_CHG_FLAG] &&
         irq_main_control_reg_r[irq_pkg::RB_CHG_EN]) ||
        (irq_main_control_reg_r[irq_pkg::EXT_FLAG] &&
         irq_main_control_reg_r[irq_pkg::EXT_EN]) ||
        (irq_main_control_reg_r[irq_pkg::TMR_FLAG] &&
         irq_main_control_reg_r[irq_pkg::TMR_EN]);
    assign periph_req = irq_main_control_reg_r[irq_pkg::PERIPH_EN] &&
        (|(periph_flag_reg_one_r & periph_enable_reg_one_r) ||
         |(periph_flag_reg_two_r & periph_enable_reg_two_r));
    assign any_req = pin_req || periph_req;
    assign irq_to_core = global_irq_enable && any_req;

    logic ack;
    assign ack = irq_to_core && instr_cycle_end &&
        core_state_r == irq_pkg::CORE_RUN;

    // ==========================================================
    // main control register; set wins over software clear
    logic [7:0] main_nxt;
    always_comb begin
        main_nxt = irq_main_control_reg_r;
        if (wr_lane0 && wr_hit(aw_addr_r, irq_pkg::ADDR_MAIN_CTRL)) begin
            main_nxt = w_data_r[7:0];
        end
        if (irq_disable_instr) begin
            main_nxt[irq_pkg::GLOBAL_EN_BIT] = 1'b0;
        end
        if (return_from_irq_instr) begin
            main_nxt[irq_pkg::GLOBAL_EN_BIT] = 1'b1;
        end
        if (ack || (core_state_r == irq_pkg::CORE_WAKE &&
                    instr_cycle_end && global_irq_enable)) begin
            main_nxt[irq_pkg::GLOBAL_EN_BIT] = 1'b0;
        end
        if (ext_event) begin
            main_nxt[irq_pkg::EXT_FLAG] = 1'b1;
        end
        if (port_event) begin
            main_nxt[irq_pkg::RB_CHG_FLAG] = 1'b1;
        end
        if (tmr_event) begin
            main_nxt[irq_pkg::TMR_FLAG] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_main_control_reg_r <= irq_pkg::MAIN_CTRL_RST;
        end else begin
            irq_main_control_reg_r <= main_nxt;
        end
    end

    // ==========================================================
    // peripheral flags, enables, option
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_flag_reg_one_r <= 7'h00;
            periph_flag_reg_two_r <= 1'h0;
            periph_enable_reg_one_r <= 7'h00;
            periph_enable_reg_two_r <= 1'h0;
            option_r <= irq_pkg::OPTION_RST;
        end else begin
            if (wr_lane0 && wr_hit(aw_addr_r, irq_pkg::ADDR_PFLAG_ONE)) begin
                periph_flag_reg_one_r <= w_data_r[6:0] |
                    periph_events.one;
            end else begin
                periph_flag_reg_one_r <= periph_flag_reg_one_r |
                    periph_events.one;
            end
            if (wr_lane0 && wr_hit(aw_addr_r, irq_pkg::ADDR_PFLAG_TWO)) begin
                periph_flag_reg_two_r <= w_data_r[0:0] |
                    periph_events.two;
            end else begin
                periph_flag_reg_two_r <= periph_flag_reg_two_r |
                    periph_events.two;
            end
            if (wr_lane0 && wr_hit(aw_addr_r, irq_pkg::ADDR_PEN_ONE)) begin
                periph_enable_reg_one_r <= w_data_r[6:0];
            end
            if (wr_lane0 && wr_hit(aw_addr_r, irq_pkg::ADDR_PEN_TWO)) begin
                periph_enable_reg_two_r <= w_data_r[0:0];
            end
            if (wr_lane0 && wr_hit(aw_addr_r, irq_pkg::ADDR_OPTION)) begin
                option_r <= w_data_r[7:0];
            end
        end
    end

    // ==========================================================
    // core sequencing: vector, sleep and wake
    logic enabled_pending;
    assign enabled_pending = any_req;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_state_r <= irq_pkg::CORE_RUN;
            vector_load <= 1'b0;
            vector_pc <= 13'h0000;
            push_return <= 1'b0;
            push_addr <= 13'h0000;
            wake_up <= 1'b0;
        end else begin
            vector_load <= 1'b0;
            push_return <= 1'b0;
            wake_up <= 1'b0;
            case (core_state_r)
                irq_pkg::CORE_RUN: begin
                    if (ack) begin
                        vector_load <= 1'b1;
                        vector_pc <= irq_pkg::IRQ_VECTOR;
                        push_return <= 1'b1;
                        push_addr <= current_pc;
                    end else if (sleep_instr) begin
                        core_state_r <= irq_pkg::CORE_SLEEP;
                    end
                end
                irq_pkg::CORE_SLEEP: begin
                    // only an enabled flag may wake, so a cause is visible
                    if (enabled_pending) begin
                        core_state_r <= irq_pkg::CORE_WAKE;
                        wake_up <= 1'b1;
                    end
                end
                irq_pkg::CORE_WAKE: begin
                    // the instruction at PC+1 runs first, then vector
                    if (instr_cycle_end) begin
                        core_state_r <= irq_pkg::CORE_RUN;
                        if (global_irq_enable) begin
                            vector_load <= 1'b1;
                            vector_pc <= irq_pkg::IRQ_VECTOR;
                            push_return <= 1'b1;
                            push_addr <= current_pc + 13'h0001;
                        end
                    end
                end
                default: begin
                    core_state_r <= irq_pkg::CORE_RUN;
                end
            endcase
        end
    end
    assign core_asleep = (core_state_r == irq_pkg::CORE_SLEEP);

    // ==========================================================
    // AXI4-Lite read path; no clear-on-read, flags clear by write
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h00000000;
        case (s_axi_araddr)
            irq_pkg::ADDR_MAIN_CTRL: rd_word[7:0] = irq_main_control_reg_r;
            irq_pkg::ADDR_PFLAG_ONE: rd_word[6:0] = periph_flag_reg_one_r;
            irq_pkg::ADDR_PFLAG_TWO: rd_word[0:0] = periph_flag_reg_two_r;
            irq_pkg::ADDR_PEN_ONE: rd_word[6:0] = periph_enable_reg_one_r;
            irq_pkg::ADDR_PEN_TWO: rd_word[0:0] = periph_enable_reg_two_r;
            irq_pkg::ADDR_OPTION: rd_word[7:0] = option_r;
            irq_pkg::ADDR_CORE: rd_word[1:0] = core_state_r;
            default: rd_word = 32'h00000000;
        endcase
    end
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= irq_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr > irq_pkg::ADDR_CORE ||
                s_axi_araddr[1:0] != 2'h0) ? irq_pkg::AXI_SLVERR
                : irq_pkg::AXI_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    enable_reset_a: assert property (@(posedge aclk)
        !aresetn |=> !global_irq_enable)
        else $error("global enable not cleared by reset");
    req_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_to_core |-> global_irq_enable && any_req)
        else $error("request without global enable");
    ack_vec_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ack |=> vector_load && vector_pc == 13'h0004 &&
            !global_irq_enable)
        else $error("acknowledge did not vector");
    reti_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        return_from_irq_instr && !ack && !irq_disable_instr
        |=> global_irq_enable)
        else $error("return did not set global enable");
    tmr_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tmr_event |=> irq_main_control_reg_r[2])
        else $error("timer wrap lost");
    port_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $changed(port_b_pins) |=> irq_main_control_reg_r[0])
        else $error("port change lost");
    sequence rise_seen;
        ext_edge_select && !ext_edge_irq_pin ##1 ext_edge_irq_pin;
    endsequence
    ext_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rise_seen ##1 ext_edge_select |=> irq_main_control_reg_r[1])
        else $error("rising edge did not set pin flag");
    wake_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wake_up |-> any_req)
        else $error("wake with no cause flag");
endmodule // interrupt_controller_core
`default_nettype wire

// ==== interrupt_controller_core_test.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bench top
module interrupt_controller_core_test;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, ext_edge_irq_pin;
    logic [7:0] s_axi_awaddr, s_axi_araddr, timer_zero_count;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, port_b_pins;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    irq_pkg::periph_events_t periph_events;
    logic [12:0] current_pc, vector_pc, push_addr, pc_prev;
    logic instr_cycle_end, return_from_irq_instr, irq_disable_instr;
    logic sleep_instr, irq_to_core, vector_load, push_return;
    logic core_asleep, wake_up, seen_wake;
    int n_fail, n_tests, cyc;
    interrupt_controller_core u_dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .ext_edge_irq_pin, .port_b_pins, .timer_zero_count, .periph_events,
        .current_pc, .instr_cycle_end, .return_from_irq_instr,
        .irq_disable_instr, .sleep_instr, .irq_to_core, .vector_load,
        .vector_pc, .push_return, .push_addr, .core_asleep, .wake_up);
    core_model u_core (.aclk, .aresetn, .vector_load, .vector_pc,
        .core_asleep, .current_pc, .instr_cycle_end);
    // pc as it stood before the latest edge, the address a vector pushes
    always @(posedge aclk) pc_prev <= current_pc;
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // ======================================================
    // checking and bus tasks
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task finish_test;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        // generous ceiling, full run needs well under 2000 cycles
        if (cyc == 20000) begin
            n_fail++;
            finish_test;
        end
    end
    task wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] r = irq_pkg::AXI_OKAY);
        logic ta, tw, tb;
        begin
            tb = 1'b0;
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata <= d;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!tb) begin
                @(negedge aclk);
                ta = s_axi_awvalid && s_axi_awready;
                tw = s_axi_wvalid && s_axi_wready;
                tb = s_axi_bvalid && s_axi_bready;
                if (tb) chk({30'h0, s_axi_bresp}, {30'h0, r});
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
                if (tb) s_axi_bready <= 1'b0;
            end
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        logic ta, tr;
        begin
            tr = 1'b0;
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!tr) begin
                @(negedge aclk);
                ta = s_axi_arvalid && s_axi_arready;
                tr = s_axi_rvalid && s_axi_rready;
                if (tr) chk(s_axi_rdata, e);
                if (tr) chk({30'h0, s_axi_rresp}, {30'h0, r});
                @(posedge aclk);
                if (ta) s_axi_arvalid <= 1'b0;
                if (tr) s_axi_rready <= 1'b0;
            end
        end
    endtask
    task wrap;
        @(posedge aclk) timer_zero_count <= 8'hFF;
        @(posedge aclk) timer_zero_count <= 8'h00;
    endtask
    // expects the vector and the pushed address: pc before it, plus off
    // looks after the edge it is called on too, so an early pulse counts
    task wait_vec(input logic [12:0] off);
        int i;
        begin
            seen_wake = 1'b0;
            #1;
            for (i = 0; i < 60 && vector_load !== 1'b1; i++) begin
                @(posedge aclk);
                #1;
                if (wake_up === 1'b1) seen_wake = 1'b1;
            end
            chk(vector_load, 1'b1);
            chk(vector_pc, irq_pkg::IRQ_VECTOR);
            chk(push_return, 1'b1);
            chk(push_addr, pc_prev + off);
        end
    endtask
    // ======================================================
    // scenarios
    task t_reset;
        rd(irq_pkg::ADDR_MAIN_CTRL, 32'h0, irq_pkg::AXI_OKAY);
        rd(irq_pkg::ADDR_OPTION, 32'hFF, irq_pkg::AXI_OKAY);
        rd(8'h1C, 32'h0, irq_pkg::AXI_SLVERR);
        wr(8'h1C, 32'hFF, irq_pkg::AXI_SLVERR);
        rd(irq_pkg::ADDR_CORE, 32'h0, irq_pkg::AXI_OKAY);
    endtask
    task t_flags;
        @(posedge aclk) ext_edge_irq_pin <= 1'b1;
        wrap();
        @(posedge aclk) port_b_pins <= 4'h8;
        periph_events <= 8'hFF;
        @(posedge aclk) periph_events <= 8'h00;
        rd(irq_pkg::ADDR_MAIN_CTRL, 32'h07, irq_pkg::AXI_OKAY);
        rd(irq_pkg::ADDR_PFLAG_ONE, 32'h7F, irq_pkg::AXI_OKAY);
        rd(irq_pkg::ADDR_PFLAG_TWO, 32'h01, irq_pkg::AXI_OKAY);
        chk(irq_to_core, 1'b0);
        wr(irq_pkg::ADDR_OPTION, 32'h0);
        wr(irq_pkg::ADDR_MAIN_CTRL, 32'h0);
        wr(irq_pkg::ADDR_PFLAG_ONE, 32'h0);
        wr(irq_pkg::ADDR_PFLAG_TWO, 32'h0);
        @(posedge aclk) ext_edge_irq_pin <= 1'b0;
        // pin edge needs two edges to reach the flag
        repeat (2) @(posedge aclk);
        rd(irq_pkg::ADDR_MAIN_CTRL, 32'h02, irq_pkg::AXI_OKAY);
        wr(irq_pkg::ADDR_MAIN_CTRL, 32'h0);
    endtask
    task t_ack;
        wr(irq_pkg::ADDR_MAIN_CTRL, 32'hA0);
        chk(irq_to_core, 1'b0);
        wrap();
        wait_vec(13'h0);
        rd(irq_pkg::ADDR_MAIN_CTRL, 32'h24, irq_pkg::AXI_OKAY);
        wr(irq_pkg::ADDR_MAIN_CTRL, 32'h20);
        @(posedge aclk) return_from_irq_instr <= 1'b1;
        @(posedge aclk) return_from_irq_instr <= 1'b0;
        rd(irq_pkg::ADDR_MAIN_CTRL, 32'hA0, irq_pkg::AXI_OKAY);
        @(posedge aclk) irq_disable_instr <= 1'b1;
        @(posedge aclk) irq_disable_instr <= 1'b0;
        rd(irq_pkg::ADDR_MAIN_CTRL, 32'h20, irq_pkg::AXI_OKAY);
    endtask
    task t_periph;
        wr(irq_pkg::ADDR_PEN_ONE, 32'h01);
        @(posedge aclk) periph_events.one <= 7'h01;
        @(posedge aclk) periph_events.one <= 7'h00;
        wr(irq_pkg::ADDR_MAIN_CTRL, 32'h80);
        chk(irq_to_core, 1'b0);
        wr(irq_pkg::ADDR_MAIN_CTRL, 32'hC0);
        wait_vec(13'h0);
        wr(irq_pkg::ADDR_PFLAG_ONE, 32'h0);
        wr(irq_pkg::ADDR_PEN_ONE, 32'h0);
        wr(irq_pkg::ADDR_PEN_TWO, 32'h01);
        @(posedge aclk) periph_events.two <= 1'b1;
        @(posedge aclk) periph_events.two <= 1'b0;
        wr(irq_pkg::ADDR_MAIN_CTRL, 32'hC0);
        wait_vec(13'h0);
        wr(irq_pkg::ADDR_PFLAG_TWO, 32'h0);
    endtask
    task t_sleep;
        wr(irq_pkg::ADDR_MAIN_CTRL, 32'hA0);
        @(posedge aclk) sleep_instr <= 1'b1;
        @(posedge aclk) sleep_instr <= 1'b0;
        rd(irq_pkg::ADDR_CORE, 32'h1, irq_pkg::AXI_OKAY);
        chk(core_asleep, 1'b1);
        wrap();
        wait_vec(13'h1);
        chk(seen_wake, 1'b1);
        rd(irq_pkg::ADDR_MAIN_CTRL, 32'h24, irq_pkg::AXI_OKAY);
    endtask
    initial begin
        n_fail = 0;
        n_tests = 0;
        cyc = 0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, ext_edge_irq_pin} = 3'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        port_b_pins = 4'h0;
        timer_zero_count = 8'h00;
        periph_events = 8'h00;
        {return_from_irq_instr, irq_disable_instr, sleep_instr} = 3'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_flags();
        t_ack();
        t_periph();
        t_sleep();
        finish_test();
    end
endmodule // interrupt_controller_core_test
`default_nettype wire

// ==== irq_pkg.sv ====
package irq_pkg;
    // ==========================================================
    // register map, byte addresses on the AXI4-Lite bus
    localparam logic [7:0] ADDR_MAIN_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PFLAG_ONE = 8'h04;
    localparam logic [7:0] ADDR_PFLAG_TWO = 8'h08;
    localparam logic [7:0] ADDR_PEN_ONE = 8'h0C;
    localparam logic [7:0] ADDR_PEN_TWO = 8'h10;
    localparam logic [7:0] ADDR_OPTION = 8'h14;
    localparam logic [7:0] ADDR_CORE = 8'h18;
    // ==========================================================
    // main control register fields, option edge select bit, peripheral group widths
    localparam int RB_CHG_FLAG = 0;
    localparam int EXT_FLAG = 1;
    localparam int TMR_FLAG = 2;
    localparam int RB_CHG_EN = 3;
    localparam int EXT_EN = 4;
    localparam int TMR_EN = 5;
    localparam int PERIPH_EN = 6;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int EDGE_SEL_BIT = 6;
    localparam int PERIPH_ONE_W = 7;
    localparam int PERIPH_TWO_W = 1;
    localparam int SOURCE_COUNT = 11;
    // ==========================================================
    // reset values and interrupt vector
    localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    // ==========================================================
    // synchroniser stages for the external pin, AXI response codes
    localparam logic [1:0] EXT_SYNC_STAGES = 2'h2;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic ext_pin;
        logic tmr_wrap;
        logic [3:0] port_hi;
    } pin_events_t;

    typedef struct packed {
        logic [6:0] one;
        logic [0:0] two;
    } periph_events_t;

    typedef enum logic [1:0] {
        CORE_RUN = 2'b00,
        CORE_SLEEP = 2'b01,
        CORE_WAKE = 2'b10
    } core_state_t;
endpackage
